// ==== pa_agc_map.svh ====
`ifndef PA_AGC_MAP_SVH
`define PA_AGC_MAP_SVH

// Register offsets (10-bit register address)
`define PA_AGC_OFS_AMP_RAMP_RATE 10'h3a7
`define PA_AGC_OFS_AMP_BIAS_TRIM 10'h3a8
`define PA_AGC_OFS_EXT_AMP_BIAS_LEVEL 10'h3a9
`define PA_AGC_OFS_AMP_POWER_EXT_CONFIG 10'h3aa
`define PA_AGC_OFS_CONVERTER_READBACK 10'h3ae
`define PA_AGC_OFS_GAIN_LNA_SWITCHING 10'h3b2
`define PA_AGC_OFS_GAIN_SATURATION_LIMIT 10'h3b4
`define PA_AGC_OFS_GAIN_UPPER_THRESHOLD 10'h3b6
`define PA_AGC_OFS_GAIN_TARGET_LEVEL 10'h3b7
`define PA_AGC_OFS_GAIN_LOWER_THRESHOLD 10'h3b8
`define PA_AGC_OFS_STRENGTH_OFFSET_AVERAGING 10'h3b9
`define PA_AGC_OFS_GAIN_POSTFILTER_TIMING 10'h3ba

// Whole-byte reset values, reserved fields included
`define PA_AGC_RST_AMP_RAMP_RATE 8'h07
`define PA_AGC_RST_AMP_BIAS_TRIM 8'h0d
`define PA_AGC_RST_EXT_AMP_BIAS_LEVEL 8'h00
`define PA_AGC_RST_AMP_POWER_EXT_CONFIG 8'hf1
`define PA_AGC_RST_GAIN_LNA_SWITCHING 8'h30
`define PA_AGC_RST_GAIN_SATURATION_LIMIT 8'h90
`define PA_AGC_RST_GAIN_UPPER_THRESHOLD 8'h2e
`define PA_AGC_RST_GAIN_TARGET_LEVEL 8'h23
`define PA_AGC_RST_GAIN_LOWER_THRESHOLD 8'h18
`define PA_AGC_RST_STRENGTH_OFFSET_AVERAGING 8'h13
`define PA_AGC_RST_GAIN_POSTFILTER_TIMING 8'h2d

// Field positions
`define PA_AGC_RAMP_CODE 2:0
`define PA_AGC_BRIDGE_TRIM 4:0
`define PA_AGC_EXT_BIAS 4:0
`define PA_AGC_OUT_LEVEL 7:4
`define PA_AGC_EXT_SRC 3
`define PA_AGC_EXT_MODE 2:0
`define PA_AGC_ADC_OUT 5:0
`define PA_AGC_LNA_HYST 6:5
`define PA_AGC_LNA_THRES 4:1
`define PA_AGC_FREEZE 0
`define PA_AGC_SAT_OFFS 5:3
`define PA_AGC_LEVEL7 6:0
`define PA_AGC_RSSI_OFFS 4:2
`define PA_AGC_RSSI_AVG 1:0
`define PA_AGC_PF_AVG 5:3
`define PA_AGC_PF_AVG_LNA 2:0

// Timing: ramp step unit and clock period, both in picoseconds
`define PA_AGC_RAMP_UNIT_PS 2400
`define PA_AGC_CLK_PERIOD_PS 100000

// Amplifier level minimum, bias DAC and servo figures (nA and uA), converter full scale
`define PA_AGC_LEVEL_MIN 4'h3
`define PA_AGC_DAC_BASE_NA 80000
`define PA_AGC_DAC_STEP_NA 2580
`define PA_AGC_SERVO_BASE_UA 22000
`define PA_AGC_SERVO_STEP_UA 349
`define PA_AGC_ADC_FULL_SCALE 6'h3f

`endif

// ==== pa_agc_pkg.sv ====
package pa_agc_pkg;

  // Ramp sequencer states, Gray along idle-up-hold-down
  typedef enum logic [1:0] {
    RAMP_IDLE = 2'b00,
    RAMP_UP = 2'b01,
    RAMP_HOLD = 2'b11,
    RAMP_DOWN = 2'b10
  } pa_agc_ramp_state_t;

  // What the external bias pin does
  typedef enum logic [2:0] {
    BIAS_FLOAT = 3'h0,
    BIAS_SOURCE = 3'h1,
    BIAS_SINK = 3'h2,
    BIAS_SERVO_POS = 3'h3,
    BIAS_SERVO_NEG = 3'h4
  } pa_agc_bias_drive_t;

endpackage : pa_agc_pkg

// ==== pa_agc_if.sv ====
`timescale 1ns/10ps
// Carries configuration from the register bank to the amplifier helpers
interface pa_agc_if;
  logic [2:0] ramp_code;
  logic [3:0] target_level;
  logic tx_on;
  logic [3:0] pa_level;
  logic pa_on;
  logic ramp_busy;
  logic [4:0] ext_bias;
  logic [2:0] ext_mode;
  logic ext_src;
  logic supply_on;
  pa_agc_pkg::pa_agc_bias_drive_t bias_drive;
  logic [16:0] dac_na;
  logic [14:0] servo_ua;
  logic ref_bandgap;

  modport bank (output ramp_code, target_level, tx_on, ext_bias, ext_mode, ext_src,
    input pa_level, pa_on, ramp_busy, supply_on, bias_drive, dac_na, servo_ua, ref_bandgap);
  modport ramp (input ramp_code, target_level, tx_on, output pa_level, pa_on, ramp_busy);
  modport ext (input ext_bias, ext_mode, ext_src,
    output supply_on, bias_drive, dac_na, servo_ua, ref_bandgap);
endinterface : pa_agc_if

// ==== pa_agc_ramp.sv ====
`timescale 1ns/10ps
`include "pa_agc_map.svh"
// Steps the amplifier level between minimum and the programmed level
module pa_agc_ramp (
  input wire logic mclk_i,
  input wire logic nrst_i,
  pa_agc_if.ramp cfg
);

  // Hold time of one step in cycles, rounded up, never below one
  function automatic logic [7:0] pa_agc_step_cycles(input logic [2:0] code);
    int unsigned ps;
    int unsigned cyc;
    ps = `PA_AGC_RAMP_UNIT_PS << code;
    cyc = (ps + `PA_AGC_CLK_PERIOD_PS - 1) / `PA_AGC_CLK_PERIOD_PS;
    if (cyc == 0) cyc = 1;
    return cyc[7:0];
  endfunction : pa_agc_step_cycles

  pa_agc_pkg::pa_agc_ramp_state_t state_reg, state_next;
  logic [7:0] cnt_reg;
  logic [3:0] level_reg;
  wire [3:0] goal = (cfg.target_level < `PA_AGC_LEVEL_MIN) ? `PA_AGC_LEVEL_MIN
                                                         : cfg.target_level;
  wire step = (cnt_reg == 8'h01); // see RULE1
  wire at_goal = (level_reg == goal);
  wire at_min = (level_reg == `PA_AGC_LEVEL_MIN);
  // Next level, one code per step interval; the output follows it so the first step
  // is held exactly as long as every later one
  wire [3:0] level_next = (state_reg == pa_agc_pkg::RAMP_IDLE) ? `PA_AGC_LEVEL_MIN
    : (step && state_reg == pa_agc_pkg::RAMP_UP && level_reg < goal) ? level_reg + 4'h1
    : (step && state_reg == pa_agc_pkg::RAMP_DOWN && !at_min) ? level_reg - 4'h1
    : level_reg; // see RULE3

  // Next state; a live level change re-enters the up/down stepping
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pa_agc_pkg::RAMP_IDLE: if (cfg.tx_on) state_next = pa_agc_pkg::RAMP_UP;
      pa_agc_pkg::RAMP_UP: begin
        if (!cfg.tx_on) state_next = pa_agc_pkg::RAMP_DOWN;
        else if (at_goal) state_next = pa_agc_pkg::RAMP_HOLD;
      end
      pa_agc_pkg::RAMP_HOLD: begin
        if (!cfg.tx_on || level_reg > goal) state_next = pa_agc_pkg::RAMP_DOWN;
        else if (level_reg < goal) state_next = pa_agc_pkg::RAMP_UP;
      end
      pa_agc_pkg::RAMP_DOWN: begin
        if (cfg.tx_on && level_reg <= goal) state_next = pa_agc_pkg::RAMP_UP;
        else if (!cfg.tx_on && at_min && step) state_next = pa_agc_pkg::RAMP_IDLE;
      end
      default: state_next = pa_agc_pkg::RAMP_IDLE;
    endcase
  end

  // Step counter reloads from the live code, so a rate change applies from the next step
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 8'h01;
    end else if (state_reg == pa_agc_pkg::RAMP_IDLE || step) begin
      cnt_reg <= pa_agc_step_cycles(cfg.ramp_code); // see RULE1
    end else begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  // State and level registers
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= pa_agc_pkg::RAMP_IDLE;
      level_reg <= `PA_AGC_LEVEL_MIN;
    end else begin
      state_reg <= state_next;
      level_reg <= level_next;
    end
  end

  // Outputs registered for the top level
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg.pa_level <= 4'h0;
      cfg.pa_on <= 1'b0;
      cfg.ramp_busy <= 1'b0;
    end else begin
      cfg.pa_level <= (state_next == pa_agc_pkg::RAMP_IDLE) ? 4'h0 : level_next; // see RULE1
      cfg.pa_on <= (state_next != pa_agc_pkg::RAMP_IDLE);
      cfg.ramp_busy <= (state_next == pa_agc_pkg::RAMP_UP)
                    || (state_next == pa_agc_pkg::RAMP_DOWN);
    end
  end

endmodule : pa_agc_ramp

// ==== pa_agc_extamp.sv ====
`timescale 1ns/10ps
`include "pa_agc_map.svh"
// Decodes the external amplifier pin mode and bias code
module pa_agc_extamp (
  input wire logic mclk_i,
  input wire logic nrst_i,
  pa_agc_if.ext cfg
);

  // Supply pin is off only in the two supply-off modes
  wire supply = !(cfg.ext_mode == 3'h3 || cfg.ext_mode == 3'h4); // see RULE5
  pa_agc_pkg::pa_agc_bias_drive_t drive;
  wire [16:0] dac = 17'(`PA_AGC_DAC_BASE_NA - `PA_AGC_DAC_STEP_NA * cfg.ext_bias);
  wire [14:0] servo = 15'(`PA_AGC_SERVO_BASE_UA - `PA_AGC_SERVO_STEP_UA * cfg.ext_bias);
  wire dac_mode = (cfg.ext_mode >= 3'h1) && (cfg.ext_mode <= 3'h4);
  wire servo_mode = (cfg.ext_mode == 3'h5) || (cfg.ext_mode == 3'h6);

  // Reserved code 7 falls back to the harmless floating pin
  always_comb begin
    case (cfg.ext_mode) // see RULE5
      3'h1, 3'h3: drive = pa_agc_pkg::BIAS_SOURCE;
      3'h2, 3'h4: drive = pa_agc_pkg::BIAS_SINK;
      3'h5: drive = pa_agc_pkg::BIAS_SERVO_POS;
      3'h6: drive = pa_agc_pkg::BIAS_SERVO_NEG;
      default: drive = pa_agc_pkg::BIAS_FLOAT;
    endcase
  end

  // Only the figure that the mode uses is nonzero
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg.supply_on <= 1'b0;
      cfg.bias_drive <= pa_agc_pkg::BIAS_FLOAT;
      cfg.dac_na <= 17'h0;
      cfg.servo_ua <= 15'h0;
      cfg.ref_bandgap <= 1'b0;
    end else begin
      cfg.supply_on <= supply;
      cfg.bias_drive <= drive;
      cfg.dac_na <= dac_mode ? dac : 17'h0; // see RULE6
      cfg.servo_ua <= servo_mode ? servo : 15'h0; // see RULE6
      cfg.ref_bandgap <= cfg.ext_src; // see RULE4
    end
  end

endmodule : pa_agc_extamp

// ==== pa_agc_config_regs.sv ====
`timescale 1ns/10ps
`include "pa_agc_map.svh"
// Behaviour
// RULE1: Step hold is 2^code times 2.4 ns; reset 7 (code rounds up to whole 100 ns clock cycles, at least one)
// RULE2: Software sets bridge trim 21 for full power
// RULE3: Output level 3 min, 15 max, 2 dB
// RULE4: Reference select: 0 resistor, 1 bandgap current
// RULE5: Pin mode codes drive supply and bias pins
// RULE6: Bias code lowers DAC or servo set point
// RULE7: Freeze bit holds gain; 0 lets it run
// RULE8: PGA steps before first LNA step, reset 8
// RULE9: LNA transition hysteresis in PGA steps, reset 1
// RULE10: Slewing above full scale minus offset, reset 2
// RULE11: Upper strength trigger, reset 46
// RULE12: Strength target, reset 35
// RULE13: Lower strength trigger, reset 24
// RULE14: Strength readback adds offset, reset 4
// RULE15: Strength averaging time field, reset 3
// RULE16: Postfilter averaging time, reset 5
// RULE17: Postfilter averaging during LNA transitions, reset 5
// RULE18: Software writes reserved bits with reset values
// RULE19: Converter result read-only, upper bits ignored
// RULE20: Fields hold last write; logic uses them directly
module pa_agc_config_regs (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [9:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic tx_on_i,
  input wire logic [5:0] adc_sample_i,
  input wire logic [7:0] rssi_raw_i,
  output logic [3:0] pa_level_o,
  output logic pa_on_o,
  output logic pa_ramp_busy_o,
  output logic [4:0] amp_bridge_bias_trim_o,
  output logic ext_amp_supply_pin_o,
  output logic [2:0] ext_amp_bias_pin_o,
  output logic [16:0] ext_amp_dac_na_o,
  output logic [14:0] ext_amp_servo_ua_o,
  output logic ext_amp_ref_bandgap_o,
  output logic gain_freeze_o,
  output logic [3:0] gain_lna_thres_o,
  output logic [1:0] gain_lna_hyst_o,
  output logic gain_slewing_o,
  output logic [6:0] gain_upper_trigger_o,
  output logic [6:0] gain_target_o,
  output logic [6:0] gain_lower_trigger_o,
  output logic [7:0] rssi_readback_o,
  output logic [1:0] rssi_avg_time_o,
  output logic [2:0] gain_postfilter_average_o,
  output logic [2:0] gain_postfilter_average_lna_o
);

  localparam int NREG = 11;

  // Register indices into the storage array
  localparam logic [3:0] IX_RAMP = 4'h0;
  localparam logic [3:0] IX_TRIM = 4'h1;
  localparam logic [3:0] IX_EXTB = 4'h2;
  localparam logic [3:0] IX_MSC = 4'h3;
  localparam logic [3:0] IX_LNA = 4'h4;
  localparam logic [3:0] IX_SAT = 4'h5;
  localparam logic [3:0] IX_HI = 4'h6;
  localparam logic [3:0] IX_TGT = 4'h7;
  localparam logic [3:0] IX_LO = 4'h8;
  localparam logic [3:0] IX_RSSI = 4'h9;
  localparam logic [3:0] IX_PF = 4'ha;
  localparam logic [3:0] IX_NONE = 4'hf;

  // Address to storage index; unmapped and read-only give IX_NONE
  function automatic logic [3:0] pa_agc_index(input logic [9:0] a);
    case (a)
      `PA_AGC_OFS_AMP_RAMP_RATE: return IX_RAMP;
      `PA_AGC_OFS_AMP_BIAS_TRIM: return IX_TRIM;
      `PA_AGC_OFS_EXT_AMP_BIAS_LEVEL: return IX_EXTB;
      `PA_AGC_OFS_AMP_POWER_EXT_CONFIG: return IX_MSC;
      `PA_AGC_OFS_GAIN_LNA_SWITCHING: return IX_LNA;
      `PA_AGC_OFS_GAIN_SATURATION_LIMIT: return IX_SAT;
      `PA_AGC_OFS_GAIN_UPPER_THRESHOLD: return IX_HI;
      `PA_AGC_OFS_GAIN_TARGET_LEVEL: return IX_TGT;
      `PA_AGC_OFS_GAIN_LOWER_THRESHOLD: return IX_LO;
      `PA_AGC_OFS_STRENGTH_OFFSET_AVERAGING: return IX_RSSI;
      `PA_AGC_OFS_GAIN_POSTFILTER_TIMING: return IX_PF;
      default: return IX_NONE;
    endcase
  endfunction : pa_agc_index

  // Reset byte of each storage slot
  function automatic logic [7:0] pa_agc_rst(input logic [3:0] ix);
    case (ix)
      IX_RAMP: return `PA_AGC_RST_AMP_RAMP_RATE;
      IX_TRIM: return `PA_AGC_RST_AMP_BIAS_TRIM;
      IX_EXTB: return `PA_AGC_RST_EXT_AMP_BIAS_LEVEL;
      IX_MSC: return `PA_AGC_RST_AMP_POWER_EXT_CONFIG;
      IX_LNA: return `PA_AGC_RST_GAIN_LNA_SWITCHING;
      IX_SAT: return `PA_AGC_RST_GAIN_SATURATION_LIMIT;
      IX_HI: return `PA_AGC_RST_GAIN_UPPER_THRESHOLD;
      IX_TGT: return `PA_AGC_RST_GAIN_TARGET_LEVEL;
      IX_LO: return `PA_AGC_RST_GAIN_LOWER_THRESHOLD;
      IX_RSSI: return `PA_AGC_RST_STRENGTH_OFFSET_AVERAGING;
      IX_PF: return `PA_AGC_RST_GAIN_POSTFILTER_TIMING;
      default: return 8'h00;
    endcase
  endfunction : pa_agc_rst

  logic [7:0] regs_reg [NREG];
  logic [5:0] adc_reg;

  // Decode of the current access
  wire [3:0] wr_ix = pa_agc_index(reg_addr_i);
  wire wr_hit = reg_wr_i && (wr_ix != IX_NONE);
  wire is_adc = (reg_addr_i == `PA_AGC_OFS_CONVERTER_READBACK);
  wire [7:0] rd_mux = is_adc ? {2'b00, adc_reg} // see RULE19
                    : (wr_ix != IX_NONE) ? regs_reg[wr_ix] : 8'h00;

  // Named fields, used without further qualification
  wire [7:0] r_msc = regs_reg[IX_MSC];
  wire [7:0] r_lna = regs_reg[IX_LNA];
  wire [7:0] r_rssi = regs_reg[IX_RSSI];
  wire [7:0] r_pf = regs_reg[IX_PF];
  wire [5:0] sat_limit = 6'(`PA_AGC_ADC_FULL_SCALE - regs_reg[IX_SAT][`PA_AGC_SAT_OFFS]);
  wire [7:0] rssi_sum = 8'(rssi_raw_i + {5'h00, r_rssi[`PA_AGC_RSSI_OFFS]}); // see RULE14

  // Writable storage; reserved bits are stored as written
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NREG; i++) begin
        regs_reg[i] <= pa_agc_rst(4'(i));
      end
    end else if (wr_hit) begin
      regs_reg[wr_ix] <= reg_wdata_i; // see RULE20
    end
  end

  // Converter result is sampled each cycle; writes to it are ignored
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      adc_reg <= 6'h00;
    end else begin
      adc_reg <= adc_sample_i; // see RULE19
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
      reg_rvalid_o <= reg_rd_i;
    end
  end

  pa_agc_if amp_if ();

  // Configuration handed to the amplifier helpers
  assign amp_if.ramp_code = regs_reg[IX_RAMP][`PA_AGC_RAMP_CODE]; // see RULE1
  assign amp_if.target_level = r_msc[`PA_AGC_OUT_LEVEL]; // see RULE3
  assign amp_if.tx_on = tx_on_i;
  assign amp_if.ext_bias = regs_reg[IX_EXTB][`PA_AGC_EXT_BIAS]; // see RULE6
  assign amp_if.ext_mode = r_msc[`PA_AGC_EXT_MODE]; // see RULE5
  assign amp_if.ext_src = r_msc[`PA_AGC_EXT_SRC]; // see RULE4

  pa_agc_ramp u_ramp (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .cfg(amp_if.ramp)
  );

  pa_agc_extamp u_extamp (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .cfg(amp_if.ext)
  );

  // Helper results are already registered; pass them straight out
  assign pa_level_o = amp_if.pa_level;
  assign pa_on_o = amp_if.pa_on;
  assign pa_ramp_busy_o = amp_if.ramp_busy;
  assign ext_amp_supply_pin_o = amp_if.supply_on;
  assign ext_amp_bias_pin_o = amp_if.bias_drive;
  assign ext_amp_dac_na_o = amp_if.dac_na;
  assign ext_amp_servo_ua_o = amp_if.servo_ua;
  assign ext_amp_ref_bandgap_o = amp_if.ref_bandgap;

  // Bridge trim and gain-loop settings registered once more so a write lands together
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      amp_bridge_bias_trim_o <= 5'h00;
      gain_freeze_o <= 1'b0;
      gain_lna_thres_o <= 4'h0;
      gain_lna_hyst_o <= 2'h0;
      gain_upper_trigger_o <= 7'h00;
      gain_target_o <= 7'h00;
      gain_lower_trigger_o <= 7'h00;
      rssi_avg_time_o <= 2'h0;
      gain_postfilter_average_o <= 3'h0;
      gain_postfilter_average_lna_o <= 3'h0;
    end else begin
      amp_bridge_bias_trim_o <= regs_reg[IX_TRIM][`PA_AGC_BRIDGE_TRIM];
      gain_freeze_o <= r_lna[`PA_AGC_FREEZE]; // see RULE7
      gain_lna_thres_o <= r_lna[`PA_AGC_LNA_THRES]; // see RULE8
      gain_lna_hyst_o <= r_lna[`PA_AGC_LNA_HYST]; // see RULE9
      gain_upper_trigger_o <= regs_reg[IX_HI][`PA_AGC_LEVEL7]; // see RULE11
      gain_target_o <= regs_reg[IX_TGT][`PA_AGC_LEVEL7]; // see RULE12
      gain_lower_trigger_o <= regs_reg[IX_LO][`PA_AGC_LEVEL7]; // see RULE13
      rssi_avg_time_o <= r_rssi[`PA_AGC_RSSI_AVG]; // see RULE15
      gain_postfilter_average_o <= r_pf[`PA_AGC_PF_AVG]; // see RULE16
      gain_postfilter_average_lna_o <= r_pf[`PA_AGC_PF_AVG_LNA]; // see RULE17
    end
  end

  // Saturation and strength readback follow the live samples
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gain_slewing_o <= 1'b0;
      rssi_readback_o <= 8'h00;
    end else begin
      gain_slewing_o <= (adc_sample_i > sat_limit); // see RULE10
      rssi_readback_o <= rssi_sum; // see RULE14
    end
  end

endmodule : pa_agc_config_regs

// ==== pa_agc_checker.sv ====
`timescale 1ns/10ps
// Watches the bank's top ports against shadow copies of a few registers
module pa_agc_checker (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [9:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic tx_on_i,
  input wire logic [5:0] adc_sample_i,
  input wire logic [7:0] rssi_raw_i,
  input wire logic [3:0] pa_level_o,
  input wire logic pa_on_o,
  input wire logic pa_ramp_busy_o,
  input wire logic ext_amp_supply_pin_o,
  input wire logic gain_slewing_o,
  input wire logic [6:0] gain_upper_trigger_o,
  input wire logic [7:0] rssi_readback_o
);
  logic [7:0] sh_ramp;
  logic [7:0] sh_ext;
  logic [7:0] sh_sat;
  logic [7:0] sh_rssi;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // Write decode for the shadowed registers
  wire wr_ramp = reg_wr_i && reg_addr_i == 10'h3a7;
  wire wr_ext = reg_wr_i && reg_addr_i == 10'h3aa;
  wire wr_sat = reg_wr_i && reg_addr_i == 10'h3b4;
  wire wr_rssi = reg_wr_i && reg_addr_i == 10'h3b9;
  // Shadows follow the port, so expectations never peek inside the bank
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sh_ramp <= 8'h07;
      sh_ext <= 8'hf1;
      sh_sat <= 8'h90;
      sh_rssi <= 8'h13;
    end else begin
      if (wr_ramp) sh_ramp <= reg_wdata_i;
      if (wr_ext) sh_ext <= reg_wdata_i;
      if (wr_sat) sh_sat <= reg_wdata_i;
      if (wr_rssi) sh_rssi <= reg_wdata_i;
    end
  end

  property p_rd_hold;
    reg_rd_i && reg_addr_i == 10'h3a7 |=> reg_rvalid_o && reg_rdata_o == $past(sh_ramp);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("ramp register readback");
  property p_adc_top;
    reg_rd_i && reg_addr_i == 10'h3ae |=> reg_rvalid_o && reg_rdata_o[7:6] == 2'h0;
  endproperty
  a_adc_top: assert property (p_adc_top) else $error("converter upper bits");
  property p_slew;
    $past(nrst_i) |-> gain_slewing_o ==
      ({2'h0, $past(adc_sample_i)} > 8'h3f - {5'h0, $past(sh_sat[5:3])});
  endproperty
  a_slew: assert property (p_slew) else $error("slewing flag");
  property p_rssi;
    $past(nrst_i) |-> rssi_readback_o == $past(rssi_raw_i) + {5'h0, $past(sh_rssi[4:2])};
  endproperty
  a_rssi: assert property (p_rssi) else $error("strength readback");
  // Tolerates one or two cycles of latency by waiting for a settled mode
  property p_supply;
    $past(nrst_i, 2) && $past(sh_ext[2:0]) == $past(sh_ext[2:0], 2) |->
      ext_amp_supply_pin_o == !($past(sh_ext[2:0]) inside {3'h3, 3'h4});
  endproperty
  a_supply: assert property (p_supply) else $error("supply pin");
  property p_start;
    $rose(tx_on_i) && !pa_on_o |=> pa_on_o && pa_level_o == 4'h3;
  endproperty
  a_start: assert property (p_start) else $error("ramp start");
  property p_step;
    sh_ramp[2:0] == 3'h7 && $past(pa_on_o) && pa_level_o > $past(pa_level_o) |=>
      $stable(pa_level_o)[*3] ##1 ($changed(pa_level_o) || !pa_ramp_busy_o);
  endproperty
  a_step: assert property (p_step) else $error("step hold time");
  property p_upper;
    reg_wr_i && reg_addr_i == 10'h3b6 |-> ##2 gain_upper_trigger_o == $past(reg_wdata_i[6:0], 2);
  endproperty
  a_upper: assert property (p_upper) else $error("upper trigger copy");
endmodule : pa_agc_checker

bind pa_agc_config_regs pa_agc_checker u_chk (
  .mclk_i, .nrst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
  .reg_rvalid_o, .tx_on_i, .adc_sample_i, .rssi_raw_i, .pa_level_o, .pa_on_o,
  .pa_ramp_busy_o, .ext_amp_supply_pin_o, .gain_slewing_o, .gain_upper_trigger_o,
  .rssi_readback_o
);

// ==== tb_pa_agc_config_regs.sv ====
`timescale 1ns/10ps
// Drives the register port and the live inputs, checks every output group
module tb_pa_agc_config_regs;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [9:0] reg_addr_i = 10'h000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic tx_on_i = 1'b0;
  logic [5:0] adc_sample_i = 6'h00;
  logic [7:0] rssi_raw_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic reg_rvalid_o;
  logic [3:0] pa_level_o;
  logic pa_on_o;
  logic pa_ramp_busy_o;
  logic [4:0] amp_bridge_bias_trim_o;
  logic ext_amp_supply_pin_o;
  logic [2:0] ext_amp_bias_pin_o;
  logic [16:0] ext_amp_dac_na_o;
  logic [14:0] ext_amp_servo_ua_o;
  logic ext_amp_ref_bandgap_o;
  logic gain_freeze_o;
  logic [3:0] gain_lna_thres_o;
  logic [1:0] gain_lna_hyst_o;
  logic gain_slewing_o;
  logic [6:0] gain_upper_trigger_o;
  logic [6:0] gain_target_o;
  logic [6:0] gain_lower_trigger_o;
  logic [7:0] rssi_readback_o;
  logic [1:0] rssi_avg_time_o;
  logic [2:0] gain_postfilter_average_o;
  logic [2:0] gain_postfilter_average_lna_o;
  int n_errors = 0;
  int checks = 0;
  int n;
  logic [7:0] rd_val;
  // Addresses, reset bytes and a pattern that keeps reserved bits at reset
  logic [9:0] ra [11] = '{10'h3a7, 10'h3a8, 10'h3a9, 10'h3aa, 10'h3b2, 10'h3b4,
    10'h3b6, 10'h3b7, 10'h3b8, 10'h3b9, 10'h3ba};
  logic [7:0] rv [11] = '{8'h07, 8'h0d, 8'h00, 8'hf1, 8'h30, 8'h90, 8'h2e, 8'h23,
    8'h18, 8'h13, 8'h2d};
  logic [7:0] wv [11] = '{8'h07, 8'h15, 8'h05, 8'hf1, 8'h4b, 8'h90, 8'h37, 8'h2a,
    8'h1d, 8'h1d, 8'h24};
  logic [2:0] pin_tbl [8] = '{3'h0, 3'h1, 3'h2, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0};

  pa_agc_config_regs dut (
    .mclk_i, .nrst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .reg_rvalid_o, .tx_on_i, .adc_sample_i, .rssi_raw_i, .pa_level_o, .pa_on_o,
    .pa_ramp_busy_o, .amp_bridge_bias_trim_o, .ext_amp_supply_pin_o, .ext_amp_bias_pin_o,
    .ext_amp_dac_na_o, .ext_amp_servo_ua_o, .ext_amp_ref_bandgap_o, .gain_freeze_o,
    .gain_lna_thres_o, .gain_lna_hyst_o, .gain_slewing_o, .gain_upper_trigger_o,
    .gain_target_o, .gain_lower_trigger_o, .rssi_readback_o, .rssi_avg_time_o,
    .gain_postfilter_average_o, .gain_postfilter_average_lna_o
  );

  // 10 MHz clock
  always #50 mclk_i = ~mclk_i;

  task automatic tally_and_finish();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t byte %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_port(input logic [16:0] got, input logic [16:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t port %h expected %h", $time, got, exp);
    end
  endtask : chk_port

  // Settle just after an edge so registered outputs are stable
  task automatic tick(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask : tick

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk_port(reg_rvalid_o, 1'b1);
    chk_byte(reg_rdata_o, exp);
  endtask : rd

  // Bounded wait for a level; running out ends the run
  task automatic wait_lv(input logic [3:0] lv, input logic on);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (!(pa_level_o === lv && pa_on_o === on) && n < 300);
    if (n >= 300) begin
      n_errors++;
      $display("MISMATCH %0t ramp wait ran out", $time);
      tally_and_finish();
    end
  endtask : wait_lv

  // Ramp up, time the climb, hold, then ramp back to idle
  task automatic ramp(input logic [2:0] c, input logic [3:0] p, input logic [3:0] lv,
    input int en);
    wr(10'h3a7, {5'h00, c});
    wr(10'h3aa, {p, 4'h1});
    @(posedge mclk_i);
    tx_on_i <= 1'b1;
    wait_lv(lv, 1'b1);
    if (en > 0) chk_port(n, en);
    tick(8);
    chk_port(pa_level_o, lv);
    chk_port(pa_ramp_busy_o, 1'b0);
    @(posedge mclk_i);
    tx_on_i <= 1'b0;
    wait_lv(4'h0, 1'b0);
  endtask : ramp

  task automatic slew(input logic [5:0] v, input logic e);
    @(posedge mclk_i);
    adc_sample_i <= v;
    tick(2);
    chk_port(gain_slewing_o, e);
  endtask : slew

  initial begin
    repeat (5) @(posedge mclk_i);
    nrst_i <= 1'b1;
    adc_sample_i <= 6'h2a;
    tick(2);
    // Reset bytes, then the field copies they imply
    foreach (ra[i]) rd(ra[i], rv[i]);
    chk_port(gain_freeze_o, 1'b0);
    chk_port(ext_amp_dac_na_o, 17'h13880);
    chk_port(ext_amp_ref_bandgap_o, 1'b0);
    // Converter readback ignores writes; unmapped place stays empty
    wr(10'h3ae, 8'hff);
    rd(10'h3ae, 8'h2a);
    wr(10'h3ab, 8'hff);
    rd(10'h3ab, 8'h00);
    foreach (ra[i]) wr(ra[i], wv[i]);
    foreach (ra[i]) rd(ra[i], wv[i]);
    chk_port(amp_bridge_bias_trim_o, 17'h15);
    chk_port(gain_freeze_o, 1'b1);
    chk_port(gain_lna_thres_o, 17'h5);
    chk_port(gain_lna_hyst_o, 17'h2);
    chk_port(gain_upper_trigger_o, 17'h37);
    chk_port(gain_target_o, 17'h2a);
    chk_port(gain_lower_trigger_o, 17'h1d);
    chk_port(rssi_avg_time_o, 17'h1);
    chk_port(gain_postfilter_average_o, 17'h4);
    chk_port(gain_postfilter_average_lna_o, 17'h4);
    // Every pin mode with bias code 5, reference select following bit 0
    for (int m = 0; m < 8; m++) begin
      wr(10'h3aa, {4'hf, m[0], m[2:0]});
      tick(3);
      chk_port(ext_amp_supply_pin_o, !(m inside {3, 4}));
      chk_port(ext_amp_bias_pin_o, pin_tbl[m]);
      chk_port(ext_amp_dac_na_o, (m inside {[1:4]}) ? 17'h1061c : 17'h0);
      chk_port(ext_amp_servo_ua_o, (m inside {5, 6}) ? 17'h4f1f : 17'h0);
      chk_port(ext_amp_ref_bandgap_o, m[0]);
    end
    // Offset 7 wraps the strength sum past 255
    @(posedge mclk_i);
    rssi_raw_i <= 8'hfe;
    tick(2);
    chk_port(rssi_readback_o, 17'h05);
    // Saturation edge for offsets 2, 0 and 7
    slew(6'h3d, 1'b0);
    slew(6'h3e, 1'b1);
    wr(10'h3b4, 8'h80);
    slew(6'h3f, 1'b0);
    wr(10'h3b4, 8'hb8);
    slew(6'h39, 1'b1);
    slew(6'h38, 1'b0);
    ramp(3'h7, 4'hf, 4'hf, 49);
    ramp(3'h6, 4'h5, 4'h5, 5);
    ramp(3'h0, 4'hf, 4'hf, 13);
    ramp(3'h0, 4'h1, 4'h3, 0);
    // Mid-run reset returns the defaults
    @(posedge mclk_i);
    nrst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    nrst_i <= 1'b1;
    tick(2);
    rd(10'h3b6, 8'h2e);
    chk_port(gain_upper_trigger_o, 17'h2e);
    tally_and_finish();
  end
endmodule : tb_pa_agc_config_regs
